// [src/tcc23_pkg.sv]
// Shared constants and types for the channel 2/3 compare control block
package tcc23_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register map
  localparam logic [7:0]  CTL_OFFSET      = 8'h1c;      // Mode control word
  localparam logic [15:0] CTL_RESET       = 16'h0000;   // Low half reset value
  localparam logic [15:0] UPPER_RESET     = 16'h0000;   // Reserved half, reads back
  localparam int          CH2_BYTE_LSB    = 0;          // Channel 2 byte in the word
  localparam int          CH3_BYTE_LSB    = 8;          // Channel 3 byte in the word

  ////////////////////////////////////////////////////////////////////////////
  // Field positions inside one channel byte
  localparam int DIR_LSB     = 0;   // Direction select, 2 bits
  localparam int FAST_BIT    = 2;   // Compare fast enable
  localparam int SHADOW_BIT  = 3;   // Compare shadow enable
  localparam int OCS_LSB     = 4;   // Compare output select, 3 bits
  localparam int CLEAR_BIT   = 7;   // Trigger clear enable
  localparam int DIVIDER_LSB = 2;   // Capture divider, input mode overlay
  localparam int FILTER_LSB  = 4;   // Capture filter, input mode overlay

  ////////////////////////////////////////////////////////////////////////////
  // Direction codes
  localparam logic [1:0] DIR_OUTPUT = 2'h0;  // Compare output
  localparam logic [1:0] DIR_OWN    = 2'h1;  // Own filtered input
  localparam logic [1:0] DIR_OTHER  = 2'h2;  // Neighbour filtered input
  localparam logic [1:0] DIR_TRIG   = 2'h3;  // Internal trigger

  // Lock level that freezes compare settings
  localparam logic [1:0] LOCK_FULL  = 2'h3;

  ////////////////////////////////////////////////////////////////////////////
  // Compare output select codes
  localparam logic [2:0] OCS_TIMING = 3'h0;
  localparam logic [2:0] OCS_SET    = 3'h1;
  localparam logic [2:0] OCS_CLEAR  = 3'h2;
  localparam logic [2:0] OCS_TOGGLE = 3'h3;
  localparam logic [2:0] OCS_LOW    = 3'h4;
  localparam logic [2:0] OCS_HIGH   = 3'h5;
  localparam logic [2:0] OCS_PWM0   = 3'h6;
  localparam logic [2:0] OCS_PWM1   = 3'h7;

  // Counter and compare width
  localparam int CNT_W = 16;

  typedef logic [7:0]       tcc23_byte_t;   // One channel's control byte
  typedef logic [CNT_W-1:0] tcc23_cnt_t;    // Counter or compare value

endpackage

// [src/tcc23_ch_if.sv]
// Configuration carrier from the control register to one compare channel
interface tcc23_ch_if;
  logic [2:0]        output_select;   // Compare output select
  logic              shadow_en;       // Compare shadow enable
  logic              fast_en;         // Compare fast enable
  logic              clear_en;        // Trigger clear enable
  logic              cv_wr;           // Compare value write strobe
  tcc23_pkg::tcc23_cnt_t cv_wdata;    // Compare value write data

  // Register side drives, channel side listens
  modport ctrl (output output_select, shadow_en, fast_en, clear_en, cv_wr, cv_wdata);
  modport chan (input  output_select, shadow_en, fast_en, clear_en, cv_wr, cv_wdata);
endinterface

// [src/tcc23_capture_div.sv]
// Capture edge divider for one input channel
module tcc23_capture_div (
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       srst,
  // Control
  input  wire logic       enable,
  input  wire logic [1:0] divider,
  // Edge in, capture out
  input  wire logic       edge_in,
  output logic            capture_q
);

  logic [2:0] cnt_q;   // Edges seen since last capture
  logic [2:0] limit;   // Last edge index before capture

  // Edges per capture is 1, 2, 4 or 8
  assign limit = 3'((4'h1 << divider) - 4'h1);

  // Edge counter, cleared while the channel is off
  always_ff @(posedge core_clk) begin
    if (srst || !enable) begin
      cnt_q <= 3'h0;
    end else if (edge_in) begin
      cnt_q <= (cnt_q >= limit) ? 3'h0 : 3'(cnt_q + 3'h1);
    end
  end

  // Capture pulse on the edge that closes a group
  always_ff @(posedge core_clk) begin
    if (srst || !enable) begin
      capture_q <= 1'b0;
    end else begin
      capture_q <= edge_in && (cnt_q >= limit);
    end
  end

  a_div_off_clear: assert property (@(posedge core_clk) disable iff (srst)
    !enable |=> (cnt_q == 3'h0) && !capture_q)
    else $error("divider not cleared while disabled");

endmodule

// [src/tcc23_channel.sv]
// Compare reference generator for one channel, with shadowed compare value
module tcc23_channel (
  // Clock and reset
  input  wire logic                  core_clk,
  input  wire logic                  srst,
  // Configuration
  tcc23_ch_if.chan                   cfg,
  // Counter and events
  input  wire tcc23_pkg::tcc23_cnt_t count_value,
  input  wire logic                  count_down,
  input  wire logic                  update_event,
  input  wire logic                  trigger_edge,
  input  wire logic                  ext_trig,
  // Reference out
  output logic                       ref_q
);

  tcc23_pkg::tcc23_cnt_t shadow_q;   // Written compare value
  tcc23_pkg::tcc23_cnt_t active_q;   // Value the comparator uses
  logic [2:0] mode_prev_q;           // Mode seen last cycle
  logic       cmp_prev_q;            // Comparison result last cycle
  logic       eq, lt, gt, cmp_res, pwm0, clr, ref_d;

  assign eq      = count_value == active_q;
  assign lt      = count_value < active_q;
  assign gt      = count_value > active_q;
  assign cmp_res = count_down ? gt : lt;
  assign pwm0    = count_down ? !gt : lt;
  assign clr     = cfg.clear_en && ext_trig;

  // Shadow copy always takes the write
  always_ff @(posedge core_clk) begin
    if (srst) shadow_q <= '0;
    else if (cfg.cv_wr) shadow_q <= cfg.cv_wdata;
  end

  // Active value: direct write, or load at update when shadowed
  always_ff @(posedge core_clk) begin
    if (srst) active_q <= '0;
    else if (cfg.cv_wr && !cfg.shadow_en) active_q <= cfg.cv_wdata;
    else if (update_event && cfg.shadow_en) active_q <= shadow_q;
  end

  // History for the PWM change rule
  always_ff @(posedge core_clk) begin
    if (srst) begin
      mode_prev_q <= tcc23_pkg::OCS_TIMING;
      cmp_prev_q  <= 1'b0;
    end else begin
      mode_prev_q <= cfg.output_select;
      cmp_prev_q  <= cmp_res;
    end
  end

  // Next reference level; clear on trigger beats every mode
  always_comb begin
    ref_d = ref_q;
    if (clr) begin
      ref_d = 1'b0;
    end else begin
      case (cfg.output_select)
        tcc23_pkg::OCS_TIMING: ref_d = ref_q;
        tcc23_pkg::OCS_SET:    if (eq) ref_d = 1'b1;
        tcc23_pkg::OCS_CLEAR:  if (eq) ref_d = 1'b0;
        tcc23_pkg::OCS_TOGGLE: if (eq) ref_d = !ref_q;
        tcc23_pkg::OCS_LOW:    ref_d = 1'b0;
        tcc23_pkg::OCS_HIGH:   ref_d = 1'b1;
        tcc23_pkg::OCS_PWM0, tcc23_pkg::OCS_PWM1: begin
          // Fast path: trigger edge acts as the match
          if (cfg.fast_en && trigger_edge) begin
            ref_d = cfg.output_select[0];
          end else if (mode_prev_q == tcc23_pkg::OCS_TIMING ||
                       mode_prev_q[2:1] == 2'b11 || cmp_res != cmp_prev_q) begin
            ref_d = cfg.output_select[0] ? !pwm0 : pwm0;
          end
        end
        default: ref_d = ref_q;
      endcase
    end
  end

  // Reference register
  always_ff @(posedge core_clk) begin
    if (srst) ref_q <= 1'b0;
    else ref_q <= ref_d;
  end

  a_clear_forces_low: assert property (@(posedge core_clk) disable iff (srst)
    clr |=> !ref_q)
    else $error("reference not cleared by trigger");
  a_timing_holds: assert property (@(posedge core_clk) disable iff (srst)
    (cfg.output_select == tcc23_pkg::OCS_TIMING) && !clr |=> $stable(ref_q))
    else $error("reference moved in timing mode");
  a_toggle_match: assert property (@(posedge core_clk) disable iff (srst)
    (cfg.output_select == tcc23_pkg::OCS_TOGGLE) && eq && !clr |=> ref_q != $past(ref_q))
    else $error("toggle on match missed");
  a_force_high: assert property (@(posedge core_clk) disable iff (srst)
    (cfg.output_select == tcc23_pkg::OCS_HIGH) && !clr |=> ref_q)
    else $error("force high not held");
  a_shadow_load: assert property (@(posedge core_clk) disable iff (srst)
    cfg.shadow_en && update_event && !cfg.cv_wr |=> active_q == $past(shadow_q))
    else $error("shadow not loaded at update");
  a_fast_match: assert property (@(posedge core_clk) disable iff (srst)
    (cfg.output_select == tcc23_pkg::OCS_PWM1) && cfg.fast_en && trigger_edge && !clr
    |=> ref_q)
    else $error("fast trigger did not act as match");

endmodule

// [src/tcc23_ctrl.sv]
// Channel 2/3 mode control register with compare and capture routing
//
// Function
// - Channel 3 direction picks output or input source.
// - Channel 2 direction picks output or input source.
// - Direction writable only while channel disabled.
// - Clear enable drives reference low on trigger.
// - Reference active high; pins take polarity bits.
// - Timing mode holds the reference level.
// - Match sets, clears or toggles the reference.
// - Force low and force high modes.
// - PWM mode 0 level versus counter direction.
// - PWM mode 1 level versus counter direction.
// - PWM level follows the compare every cycle after timing or any PWM mode, same one included; after other modes only on compare change.
// - Full lock freezes compare select and shadow bits of a channel in output direction.
// - Shadowed compare value loads at update event.
// - Fast enable treats trigger edge as match in PWM modes.
// - Channel 3 fields behave like channel 2.
// - Capture divider groups 1, 2, 4 or 8 edges.
module tcc23_ctrl (
  // Clock and reset
  input  wire logic                  core_clk,
  input  wire logic                  srst,
  // Register port
  input  wire logic                  reg_wr_en,
  input  wire logic                  reg_rd_en,
  input  wire logic                  reg_word,
  input  wire logic [7:0]            reg_addr,
  input  wire logic [31:0]           reg_wdata,
  output logic [31:0]                reg_rdata_q,
  output logic                       reg_rvalid_q,
  // Neighbouring register fields
  input  wire logic                  ch2_channel_enable,
  input  wire logic                  ch3_channel_enable,
  input  wire logic                  ch2_main_output_polarity,
  input  wire logic                  ch2_complement_output_polarity,
  input  wire logic                  ch3_main_output_polarity,
  input  wire logic [1:0]            write_lock_level,
  // Compare value writes
  input  wire logic                  ch2_compare_value_wr,
  input  wire logic                  ch3_compare_value_wr,
  input  wire tcc23_pkg::tcc23_cnt_t compare_value_wdata,
  // Counter and events
  input  wire tcc23_pkg::tcc23_cnt_t timer_count_value,
  input  wire logic                  count_down,
  input  wire logic                  update_event,
  input  wire logic                  trigger_edge,
  input  wire logic                  filtered_external_trigger,
  // Filtered input edges
  input  wire logic                  ch2_filtered_input_to_ch2,
  input  wire logic                  ch3_filtered_input_to_ch2,
  input  wire logic                  ch3_filtered_input_to_ch3,
  input  wire logic                  ch2_filtered_input_to_ch3,
  input  wire logic                  internal_trigger_input,
  // Channel outputs
  output logic                       ch2_output_reference,
  output logic                       ch3_output_reference,
  output logic                       ch2_main_output_q,
  output logic                       ch2_complement_output_q,
  output logic                       ch3_main_output_q,
  // Capture path outputs
  output logic                       ch2_input_source_q,
  output logic                       ch3_input_source_q,
  output logic                       ch2_capture_q,
  output logic                       ch3_capture_q,
  output logic [3:0]                 ch2_capture_filter_q,
  output logic [3:0]                 ch3_capture_filter_q
);

  ////////////////////////////////////////////////////////////////////////////
  // Control word storage

  tcc23_pkg::tcc23_byte_t ch2_q;   // Channel 2 control byte
  tcc23_pkg::tcc23_byte_t ch3_q;   // Channel 3 control byte
  logic                   ctl_wr;  // Accepted word write
  logic [1:0]             ch2_direction_select;
  logic [1:0]             ch3_direction_select;

  // Narrow accesses are dropped rather than merged, so a byte store never
  // leaves half a field behind
  assign ctl_wr = reg_wr_en && reg_word && (reg_addr == tcc23_pkg::CTL_OFFSET);

  assign ch2_direction_select = ch2_q[tcc23_pkg::DIR_LSB +: 2];
  assign ch3_direction_select = ch3_q[tcc23_pkg::DIR_LSB +: 2];

  // Merge a write into one channel byte under the enable and lock gates
  function automatic tcc23_pkg::tcc23_byte_t merge_byte(
    input tcc23_pkg::tcc23_byte_t old_b,
    input tcc23_pkg::tcc23_byte_t new_b,
    input logic                   chan_en,
    input logic [1:0]             lock);
    tcc23_pkg::tcc23_byte_t res;
    logic                   frozen;
    res    = new_b;
    frozen = (lock == tcc23_pkg::LOCK_FULL) &&
             (old_b[tcc23_pkg::DIR_LSB +: 2] == tcc23_pkg::DIR_OUTPUT);
    // Direction sticks while the channel runs
    if (chan_en) begin
      res[tcc23_pkg::DIR_LSB +: 2] = old_b[tcc23_pkg::DIR_LSB +: 2];
    end
    // Locked output channel keeps its compare select and shadow bits
    if (frozen) begin
      res[tcc23_pkg::OCS_LSB +: 3]  = old_b[tcc23_pkg::OCS_LSB +: 3];
      res[tcc23_pkg::SHADOW_BIT]    = old_b[tcc23_pkg::SHADOW_BIT];
    end
    return res;
  endfunction

  // Channel 2 byte
  always_ff @(posedge core_clk) begin
    if (srst) begin
      ch2_q <= tcc23_pkg::CTL_RESET[tcc23_pkg::CH2_BYTE_LSB +: 8];
    end else if (ctl_wr) begin
      ch2_q <= merge_byte(ch2_q, reg_wdata[tcc23_pkg::CH2_BYTE_LSB +: 8],
                          ch2_channel_enable, write_lock_level);
    end
  end

  // Channel 3 byte, same gating as channel 2
  always_ff @(posedge core_clk) begin
    if (srst) begin
      ch3_q <= tcc23_pkg::CTL_RESET[tcc23_pkg::CH3_BYTE_LSB +: 8];
    end else if (ctl_wr) begin
      ch3_q <= merge_byte(ch3_q, reg_wdata[tcc23_pkg::CH3_BYTE_LSB +: 8],
                          ch3_channel_enable, write_lock_level);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read side

  // Reserved half reads as its reset value; unmapped reads give zero
  always_ff @(posedge core_clk) begin
    if (srst) begin
      reg_rdata_q  <= 32'h0000_0000;
      reg_rvalid_q <= 1'b0;
    end else begin
      reg_rvalid_q <= reg_rd_en;
      if (reg_rd_en && reg_addr == tcc23_pkg::CTL_OFFSET) begin
        reg_rdata_q <= {tcc23_pkg::UPPER_RESET, ch3_q, ch2_q};
      end else begin
        reg_rdata_q <= 32'h0000_0000;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Compare channels

  tcc23_ch_if ch2_cfg ();
  tcc23_ch_if ch3_cfg ();

  // Fields are only meaningful in output mode; in input mode the same bits
  // are the filter and divider, so the compare engine is parked in timing
  assign ch2_cfg.output_select = (ch2_direction_select == tcc23_pkg::DIR_OUTPUT) ?
                                 ch2_q[tcc23_pkg::OCS_LSB +: 3] : tcc23_pkg::OCS_TIMING;
  assign ch2_cfg.shadow_en     = ch2_q[tcc23_pkg::SHADOW_BIT];
  assign ch2_cfg.fast_en       = ch2_q[tcc23_pkg::FAST_BIT];
  assign ch2_cfg.clear_en      = ch2_q[tcc23_pkg::CLEAR_BIT] &&
                                 (ch2_direction_select == tcc23_pkg::DIR_OUTPUT);
  assign ch2_cfg.cv_wr         = ch2_compare_value_wr;
  assign ch2_cfg.cv_wdata      = compare_value_wdata;

  assign ch3_cfg.output_select = (ch3_direction_select == tcc23_pkg::DIR_OUTPUT) ?
                                 ch3_q[tcc23_pkg::OCS_LSB +: 3] : tcc23_pkg::OCS_TIMING;
  assign ch3_cfg.shadow_en     = ch3_q[tcc23_pkg::SHADOW_BIT];
  assign ch3_cfg.fast_en       = ch3_q[tcc23_pkg::FAST_BIT];
  assign ch3_cfg.clear_en      = ch3_q[tcc23_pkg::CLEAR_BIT] &&
                                 (ch3_direction_select == tcc23_pkg::DIR_OUTPUT);
  assign ch3_cfg.cv_wr         = ch3_compare_value_wr;
  assign ch3_cfg.cv_wdata      = compare_value_wdata;

  // Channel 2 reference
  tcc23_channel u_ch2 (
    .core_clk     (core_clk),
    .srst         (srst),
    .cfg          (ch2_cfg),
    .count_value  (timer_count_value),
    .count_down   (count_down),
    .update_event (update_event),
    .trigger_edge (trigger_edge),
    .ext_trig     (filtered_external_trigger),
    .ref_q        (ch2_output_reference)
  );

  // Channel 3 reference, identical engine
  tcc23_channel u_ch3 (
    .core_clk     (core_clk),
    .srst         (srst),
    .cfg          (ch3_cfg),
    .count_value  (timer_count_value),
    .count_down   (count_down),
    .update_event (update_event),
    .trigger_edge (trigger_edge),
    .ext_trig     (filtered_external_trigger),
    .ref_q        (ch3_output_reference)
  );

  // Pin levels: polarity bit set means active low
  always_ff @(posedge core_clk) begin
    if (srst) begin
      ch2_main_output_q       <= 1'b0;
      ch2_complement_output_q <= 1'b0;
      ch3_main_output_q       <= 1'b0;
    end else begin
      ch2_main_output_q       <= ch2_output_reference ^ ch2_main_output_polarity;
      ch2_complement_output_q <= !ch2_output_reference ^ ch2_complement_output_polarity;
      ch3_main_output_q       <= ch3_output_reference ^ ch3_main_output_polarity;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Input routing and capture division

  logic ch2_sel;   // Selected edge for channel 2
  logic ch3_sel;   // Selected edge for channel 3

  // Output mode routes nothing into the capture path
  always_comb begin
    case (ch2_direction_select)
      tcc23_pkg::DIR_OWN:   ch2_sel = ch2_filtered_input_to_ch2;
      tcc23_pkg::DIR_OTHER: ch2_sel = ch3_filtered_input_to_ch2;
      tcc23_pkg::DIR_TRIG:  ch2_sel = internal_trigger_input;
      default:              ch2_sel = 1'b0;
    endcase
  end

  always_comb begin
    case (ch3_direction_select)
      tcc23_pkg::DIR_OWN:   ch3_sel = ch3_filtered_input_to_ch3;
      tcc23_pkg::DIR_OTHER: ch3_sel = ch2_filtered_input_to_ch3;
      tcc23_pkg::DIR_TRIG:  ch3_sel = internal_trigger_input;
      default:              ch3_sel = 1'b0;
    endcase
  end

  // Registered source and filter setting for the neighbouring capture unit
  always_ff @(posedge core_clk) begin
    if (srst) begin
      ch2_input_source_q   <= 1'b0;
      ch3_input_source_q   <= 1'b0;
      ch2_capture_filter_q <= 4'h0;
      ch3_capture_filter_q <= 4'h0;
    end else begin
      ch2_input_source_q   <= ch2_sel;
      ch3_input_source_q   <= ch3_sel;
      ch2_capture_filter_q <= ch2_q[tcc23_pkg::FILTER_LSB +: 4];
      ch3_capture_filter_q <= ch3_q[tcc23_pkg::FILTER_LSB +: 4];
    end
  end

  // Channel 2 divider runs only as an enabled input
  tcc23_capture_div u_ch2_div (
    .core_clk  (core_clk),
    .srst      (srst),
    .enable    (ch2_channel_enable && ch2_direction_select != tcc23_pkg::DIR_OUTPUT),
    .divider   (ch2_q[tcc23_pkg::DIVIDER_LSB +: 2]),
    .edge_in   (ch2_sel),
    .capture_q (ch2_capture_q)
  );

  // Channel 3 divider
  tcc23_capture_div u_ch3_div (
    .core_clk  (core_clk),
    .srst      (srst),
    .enable    (ch3_channel_enable && ch3_direction_select != tcc23_pkg::DIR_OUTPUT),
    .divider   (ch3_q[tcc23_pkg::DIVIDER_LSB +: 2]),
    .edge_in   (ch3_sel),
    .capture_q (ch3_capture_q)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  a_dir_enabled_lock: assert property (@(posedge core_clk) disable iff (srst)
    ctl_wr && ch2_channel_enable |=> ch2_direction_select == $past(ch2_direction_select))
    else $error("direction changed while channel enabled");
  a_dir3_enabled_lock: assert property (@(posedge core_clk) disable iff (srst)
    ctl_wr && ch3_channel_enable |=> ch3_direction_select == $past(ch3_direction_select))
    else $error("channel 3 direction changed while enabled");
  a_own_route: assert property (@(posedge core_clk) disable iff (srst)
    ch3_direction_select == tcc23_pkg::DIR_OWN |=>
    ch3_input_source_q == $past(ch3_filtered_input_to_ch3))
    else $error("own input not routed to channel 3");
  a_full_lock_ctl: assert property (@(posedge core_clk) disable iff (srst)
    ctl_wr && write_lock_level == tcc23_pkg::LOCK_FULL &&
    ch3_direction_select == tcc23_pkg::DIR_OUTPUT |=> ch3_q[6:3] == $past(ch3_q[6:3]))
    else $error("locked compare fields changed");
  a_narrow_ignored: assert property (@(posedge core_clk) disable iff (srst)
    reg_wr_en && !reg_word |=> $stable(ch2_q) && $stable(ch3_q))
    else $error("narrow write changed the register");
  a_trig_route: assert property (@(posedge core_clk) disable iff (srst)
    ch2_direction_select == tcc23_pkg::DIR_TRIG |=>
    ch2_input_source_q == $past(internal_trigger_input))
    else $error("trigger not routed to channel 2");
  a_pin_polarity: assert property (@(posedge core_clk) disable iff (srst)
    1'b1 |=> ch2_main_output_q == ($past(ch2_output_reference) ^
                                   $past(ch2_main_output_polarity)))
    else $error("main output polarity wrong");

endmodule

// [bench/tcc23_ctrl_tb_top.sv]
// Self-checking bench for the channel 2/3 compare control block
module tcc23_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // Row: control word, count, compare value, down, expected refs
  typedef struct {logic [15:0] w, c, v; logic d, e2, e3;} tcc23_row_t;
  logic        core_clk = 0, srst = 1, we = 0, re = 0, word = 1, pol = 0, cw = 0;
  logic        up_ev = 0, trg = 0, etr = 0, e22 = 0, e32 = 0, dn = 0, en2 = 0, itr = 0;
  logic [7:0]  addr = 8'h1c;
  logic [31:0] wd = 0;
  logic [15:0] cnt = 0, cvw = 0;
  logic [1:0]  lock = 0;
  wire  [31:0] rdata;
  wire         rv, r2, r3, m2, n2, m3, s2, s3, c2, c3;
  wire  [3:0]  f2, f3;
  int          n_mismatch = 0, n_tests = 0, ncap = 0;
  tcc23_row_t  rows [12] = '{
    '{16'h5050, 5, 5, 0, 1, 1}, '{16'h4000, 5, 5, 0, 1, 0}, '{16'h5040, 5, 5, 0, 0, 1},
    '{16'h4010, 5, 5, 0, 1, 0}, '{16'h5020, 5, 5, 0, 0, 1}, '{16'h4000, 5, 5, 0, 0, 0},
    '{16'h5060, 3, 5, 0, 1, 1}, '{16'h4070, 3, 5, 0, 0, 0}, '{16'h5070, 7, 5, 1, 1, 1},
    '{16'h4060, 7, 5, 1, 0, 0}, '{16'h5060, 5, 5, 1, 1, 1}, '{16'h4070, 5, 5, 0, 1, 0}};

  tcc23_ctrl tcc23_ctrl_inst (.core_clk(core_clk), .srst(srst), .reg_wr_en(we),
    .reg_rd_en(re), .reg_word(word), .reg_addr(addr), .reg_wdata(wd), .reg_rdata_q(rdata),
    .reg_rvalid_q(rv), .ch2_channel_enable(en2), .ch3_channel_enable(en2),
    .ch2_main_output_polarity(pol), .ch2_complement_output_polarity(pol),
    .ch3_main_output_polarity(pol), .write_lock_level(lock), .ch2_compare_value_wr(cw),
    .ch3_compare_value_wr(cw), .compare_value_wdata(cvw), .timer_count_value(cnt),
    .count_down(dn), .update_event(up_ev), .trigger_edge(trg),
    .filtered_external_trigger(etr), .ch2_filtered_input_to_ch2(e22),
    .ch3_filtered_input_to_ch2(e32), .ch3_filtered_input_to_ch3(e32),
    .ch2_filtered_input_to_ch3(e22), .internal_trigger_input(itr),
    .ch2_output_reference(r2), .ch3_output_reference(r3), .ch2_main_output_q(m2),
    .ch2_complement_output_q(n2), .ch3_main_output_q(m3), .ch2_input_source_q(s2),
    .ch3_input_source_q(s3), .ch2_capture_q(c2), .ch3_capture_q(c3),
    .ch2_capture_filter_q(f2), .ch3_capture_filter_q(f3));

  ////////////////////////////////////////////////////////////////////////////
  // Clock, capture pulse counter
  initial forever #2.5 core_clk = ~core_clk;
  always @(posedge core_clk) ncap <= ncap + int'(c2 === 1'b1);

  // Inputs change 1 ns after the edge, never on it
  task automatic tick(int n = 1);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic chk(logic [31:0] got, logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(logic [31:0] d);
    wd = d; we = 1; tick(); we = 0;
  endtask
  // Read answer lands one edge after the strobe
  task automatic rd(logic [31:0] exp);
    re = 1; tick(); re = 0;
    chk(rv, 1);
    chk(rdata, exp);
  endtask
  task automatic cv(logic [15:0] v);
    cvw = v; cw = 1; tick(); cw = 0;
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // Whole run needs well under 2000 cycles
  initial begin
    #20us; n_mismatch++; tally_and_finish();
  end

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    tick(12); srst = 0; tick();
    rd(0); chk(r2, 0); $display("test reset done");
    foreach (rows[i]) begin
      cnt = rows[i].c; dn = rows[i].d; cv(rows[i].v); wr(rows[i].w); tick(2);
      chk(r2, rows[i].e2);
      chk(r3, rows[i].e3);
      chk(m2, rows[i].e2);
      chk(m3, rows[i].e3);
      rd({16'h0, rows[i].w});
    end
    $display("test mode table done");
    cnt = 6; wr(32'h30); tick(2); chk(r2, 1);
    cnt = 5; tick(); cnt = 6; tick(2); chk(r2, 0);
    wr(32'hd0); etr = 1; tick(2); chk(r2, 0);
    etr = 0; tick(2); chk(r2, 1);
    pol = 1; tick(2); chk(m2, 0); chk(n2, 1); chk(m3, 1); pol = 0;
    $display("test toggle clear polarity done");
    lock = 3; wr(32'he8); rd(32'hd0); lock = 0;
    word = 0; wr(32'h0); word = 1; rd(32'hd0);
    addr = 8'h20; wr(32'h0); rd(0); tick(); addr = 8'h1c; rd(32'hd0);
    $display("test lock and refused writes done");
    cnt = 5; cv(10); wr(32'h68); tick(2); chk(r2, 1);
    cv(3); tick(2); chk(r2, 1);
    up_ev = 1; tick(); up_ev = 0; tick(2); chk(r2, 0);
    cnt = 1; wr(32'h7c); tick(3); chk(r2, 0);
    trg = 1; tick(); trg = 0; chk(r2, 1);
    $display("test shadow and fast done");
    en2 = 1; wr(32'h0202); rd(32'h0);
    en2 = 0; wr(32'h6); rd(32'h6); en2 = 1; ncap = 0;
    e22 = 1; tick(); e22 = 0; tick(3); chk(ncap, 0);
    e32 = 1; tick(); e32 = 0; tick(); e32 = 1; tick(); e32 = 0; tick(3);
    chk(ncap, 1);
    // Trigger source for direction 11 is picked outside this block
    en2 = 0; wr(32'ha153); rd(32'ha153); en2 = 1; itr = 1; e32 = 1;
    tick(); itr = 0; e32 = 0; chk(s2, 1); chk(c2, 1); chk(f2, 4'h5);
    chk(s3, 1); chk(c3, 1); chk(f3, 4'ha);
    tick(); chk(s2, 0); chk(s3, 0); chk(c3, 0);
    $display("test direction and capture done");
    tally_and_finish();
  end
endmodule
